// File: include/hash_txq_pkg.sv
// Package for the transmit-space request and multicast hash filter.
// Assumes a 16-bit parallel host bus with byte addresses and one clock.
package hash_txq_pkg;

  // ------------------------------------------------------------
  // Register offsets (byte addresses on the host bus)
  // ------------------------------------------------------------
  localparam logic [11:0] OFS_TX_NEXT_FRAME_SPACE_REQUEST = 12'h19E;
  localparam logic [11:0] OFS_MULTICAST_HASH_TABLE_WORD0 = 12'h1A0;
  localparam logic [11:0] OFS_MULTICAST_HASH_TABLE_WORD1 = 12'h1A2;
  localparam logic [11:0] OFS_MULTICAST_HASH_TABLE_WORD2 = 12'h1A4;
  localparam logic [11:0] OFS_MULTICAST_HASH_TABLE_WORD3 = 12'h1A6;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] RST_TX_NEXT_FRAME_SPACE_REQUEST = 16'h0000;
  localparam logic [15:0] RST_MULTICAST_HASH_TABLE = 16'h0000;

  // ------------------------------------------------------------
  // Field positions and hash constants
  // ------------------------------------------------------------
  localparam int HASH_WORD_MSB = 5; // Index bits choosing the word
  localparam int HASH_WORD_LSB = 4;
  localparam int HASH_BIT_MSB = 3; // Index bits choosing the bit
  localparam int CRC_INDEX_LSB = 26; // Six top CRC bits form the index
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

  // Register select codes produced by the address decoder
  typedef enum logic [2:0] {
    SEL_SPACE_REQ,
    SEL_HASH0,
    SEL_HASH1,
    SEL_HASH2,
    SEL_HASH3,
    SEL_NONE
  } reg_sel_e;

  // Whole state of the block
  typedef struct packed {
    logic [15:0] space_req;
    logic [3:0][15:0] hash_tbl;
    logic space_met;
    logic space_flag;
    logic [15:0] rdata;
    logic rvalid;
    logic flt_valid;
    logic flt_accept;
    logic [5:0] flt_index;
  } state_s;

endpackage

// File: core/mac_hash_filter_txq_space.sv
// Transmit-space request register and multicast hash filter.
// Assumes host bus and receive path logic run on clk; loose control
// bits from neighbouring registers arrive as plain ports.
//
// Function
// - 16-bit request register, dword units, resets zero
// - Monitor enabled: flag when free reaches request
// - Hash table used only in hash-perfect mode
// - Index is six top CRC bits of DA
// - Top two bits pick word, four pick bit
// - Bit one accepts frame, zero drops it
// - Receive-all plus address filter accepts all multicast
// - Four 16-bit read/write words, reset zero
// - Space-available event reported as sticky status bit
module mac_hash_filter_txq_space
  import hash_txq_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host register bus
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [1:0] reg_be,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // Transmit queue space monitor
  input wire logic space_monitor_en,
  input wire logic [15:0] txq_free_dwords,
  input wire logic space_flag_clear,
  output logic tx_space_available_flag,
  // Receive control bits
  input wire logic hash_perfect_mode,
  input wire logic rx_receive_all,
  input wire logic rx_multicast_with_addr,
  // Received destination address
  input wire logic rx_da_valid,
  input wire logic [47:0] rx_da,
  input wire logic rx_da_multicast,
  // Filter verdict
  output logic rx_filter_valid,
  output logic rx_accept,
  output logic [5:0] rx_hash_index
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------

  // Address decode, shared by write and read paths
  function automatic reg_sel_e decode(input logic [11:0] a);
    case (a)
      OFS_TX_NEXT_FRAME_SPACE_REQUEST: decode = SEL_SPACE_REQ;
      OFS_MULTICAST_HASH_TABLE_WORD0: decode = SEL_HASH0;
      OFS_MULTICAST_HASH_TABLE_WORD1: decode = SEL_HASH1;
      OFS_MULTICAST_HASH_TABLE_WORD2: decode = SEL_HASH2;
      OFS_MULTICAST_HASH_TABLE_WORD3: decode = SEL_HASH3;
      default: decode = SEL_NONE;
    endcase
  endfunction

  // Byte-lane merge for 16-bit writes
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] wd,
                                        input logic [1:0] be);
    merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // CRC-32 over the DA; bit 0 is the first bit on the wire
  function automatic logic [5:0] hash_of(input logic [47:0] da);
    logic [31:0] crc;
    logic fb;
    crc = CRC_INIT;
    fb = 1'b0;
    for (int i = 0; i < 48; i++) begin
      fb = crc[31] ^ da[i];
      crc = {crc[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
    end
    hash_of = crc[31:CRC_INDEX_LSB];
  endfunction

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  state_s st_r;
  state_s st_nxt;
  reg_sel_e wsel;
  reg_sel_e rsel;
  logic [5:0] idx_now;
  logic [1:0] idx_word;
  logic [3:0] idx_bit;
  logic hit_bit;
  logic space_ok;

  // Combinational lookups used by the next-state logic
  always_comb begin
    wsel = decode(reg_addr);
    rsel = decode(reg_addr);
    idx_now = hash_of(rx_da);
    idx_word = idx_now[HASH_WORD_MSB:HASH_WORD_LSB];
    idx_bit = idx_now[HASH_BIT_MSB:0];
    // Word from top two bits, bit from low four
    hit_bit = st_r.hash_tbl[idx_word][idx_bit];
    // Request is in dwords, free space counted in dwords too
    space_ok = txq_free_dwords >= st_r.space_req;
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rvalid = 1'b0;
    st_nxt.flt_valid = 1'b0;

    // Register writes; unmapped addresses are ignored
    if (reg_wr) begin
      case (wsel)
        SEL_SPACE_REQ: begin
          st_nxt.space_req = merge(st_r.space_req, reg_wdata, reg_be);
          // A fresh request re-arms the monitor for the next frame
          st_nxt.space_met = 1'b0;
        end
        SEL_HASH0, SEL_HASH1, SEL_HASH2, SEL_HASH3: begin
          for (int k = 0; k < 4; k++) begin
            if (int'(wsel) == k + 1) begin
              st_nxt.hash_tbl[k] = merge(st_r.hash_tbl[k], reg_wdata, reg_be);
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads; unmapped addresses answer zero
    if (reg_rd) begin
      st_nxt.rvalid = 1'b1;
      case (rsel)
        SEL_SPACE_REQ: st_nxt.rdata = st_r.space_req;
        SEL_HASH0: st_nxt.rdata = st_r.hash_tbl[0];
        SEL_HASH1: st_nxt.rdata = st_r.hash_tbl[1];
        SEL_HASH2: st_nxt.rdata = st_r.hash_tbl[2];
        SEL_HASH3: st_nxt.rdata = st_r.hash_tbl[3];
        default: st_nxt.rdata = 16'h0000;
      endcase
    end

    // Space monitor: fire once as free space first reaches the request.
    // Latched by space_met so a still-satisfied request does not refire after clear.
    if (space_flag_clear) begin
      st_nxt.space_flag = 1'b0;
    end
    if (!space_monitor_en) begin
      st_nxt.space_met = 1'b0;
    end else if (space_ok && !st_r.space_met && !(reg_wr && wsel == SEL_SPACE_REQ)) begin
      st_nxt.space_met = 1'b1;
      st_nxt.space_flag = 1'b1; // (set beats clear)
    end

    // Receive filter verdict, one cycle after the DA
    if (rx_da_valid) begin
      st_nxt.flt_valid = 1'b1;
      st_nxt.flt_index = idx_now;
      if (!rx_da_multicast) begin
        st_nxt.flt_accept = 1'b1; // Unicast is not this filter's job
      end else if (rx_receive_all && rx_multicast_with_addr) begin
        st_nxt.flt_accept = 1'b1;
      end else if (hash_perfect_mode) begin
        st_nxt.flt_accept = hit_bit;
      end else begin
        st_nxt.flt_accept = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.space_req <= RST_TX_NEXT_FRAME_SPACE_REQUEST;
      st_r.hash_tbl <= {4{RST_MULTICAST_HASH_TABLE}};
      st_r.space_met <= 1'b0;
      st_r.space_flag <= 1'b0;
      st_r.rdata <= 16'h0000;
      st_r.rvalid <= 1'b0;
      st_r.flt_valid <= 1'b0;
      st_r.flt_accept <= 1'b0;
      st_r.flt_index <= 6'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all straight from flip-flops
  // ------------------------------------------------------------
  assign reg_rdata = st_r.rdata;
  assign reg_rvalid = st_r.rvalid;
  assign tx_space_available_flag = st_r.space_flag;
  assign rx_filter_valid = st_r.flt_valid;
  assign rx_accept = st_r.flt_accept;
  assign rx_hash_index = st_r.flt_index;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------

  // Full-word write lands in the request register
  a_space_req_write:
    assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_be == 2'b11 && reg_addr == OFS_TX_NEXT_FRAME_SPACE_REQUEST
      |=> st_r.space_req == $past(reg_wdata))
    else $error("space request not written");

  // Request read back two cycles after a write
  a_space_req_read:
    assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_be == 2'b11 && reg_addr == OFS_TX_NEXT_FRAME_SPACE_REQUEST
      ##1 reg_rd && !reg_wr && reg_addr == OFS_TX_NEXT_FRAME_SPACE_REQUEST
      |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2))
    else $error("space request readback wrong");

  // Flag raised one cycle after space first suffices
  a_flag_set:
    assert property (@(posedge clk) disable iff (!rst_n)
      space_monitor_en && space_ok && !st_r.space_met && !reg_wr
      |=> tx_space_available_flag)
    else $error("space flag not raised");

  // Flag only rises with the monitor enabled and space present
  a_flag_cause:
    assert property (@(posedge clk) disable iff (!rst_n)
      $rose(tx_space_available_flag)
      |-> $past(space_monitor_en) && $past(space_ok))
    else $error("space flag rose without cause");

  // Flag is sticky until cleared
  a_flag_sticky:
    assert property (@(posedge clk) disable iff (!rst_n)
      tx_space_available_flag && !space_flag_clear |=> tx_space_available_flag)
    else $error("space flag dropped");

  // Index follows the DA one cycle later
  a_hash_index:
    assert property (@(posedge clk) disable iff (!rst_n)
      rx_da_valid |=> rx_filter_valid && rx_hash_index == $past(idx_now))
    else $error("hash index wrong");

  // Word and bit chosen from the index decide the verdict
  a_hash_verdict:
    assert property (@(posedge clk) disable iff (!rst_n)
      rx_da_valid && rx_da_multicast && hash_perfect_mode
      && !(rx_receive_all && rx_multicast_with_addr)
      |=> rx_accept == st_r.hash_tbl[$past(idx_word)][$past(idx_bit)]
          || $past(reg_wr))
    else $error("hash verdict wrong");

  // Receive-all with address filtering passes every multicast
  a_receive_all:
    assert property (@(posedge clk) disable iff (!rst_n)
      rx_da_valid && rx_receive_all && rx_multicast_with_addr |=> rx_accept)
    else $error("multicast dropped under receive-all");

  // Outside hash mode the table never drops a frame
  a_hash_bypass:
    assert property (@(posedge clk) disable iff (!rst_n)
      rx_da_valid && !hash_perfect_mode |=> rx_accept)
    else $error("frame dropped outside hash mode");

  // Table word 3 read returns its stored value
  a_table_read:
    assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == OFS_MULTICAST_HASH_TABLE_WORD3
      |=> reg_rvalid && reg_rdata == $past(st_r.hash_tbl[3]))
    else $error("hash word readback wrong");

  // Index below 16 always uses word 0
  a_low_map:
    assert property (@(posedge clk) disable iff (!rst_n)
      rx_da_valid && idx_now < 6'd16 |-> hit_bit == st_r.hash_tbl[0][idx_now[3:0]])
    else $error("low index mapped wrong");

  // Already fired and now cleared: no refire until re-armed
  a_fire_once:
    assert property (@(posedge clk) disable iff (!rst_n)
      st_r.space_met && space_flag_clear |=> !tx_space_available_flag)
    else $error("space flag refired without re-arm");

  // Holes in the map answer zero, never a table word
  a_unmapped_read:
    assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && rsel == SEL_NONE |=> reg_rvalid && reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  // Individual addresses are never dropped by the group filter
  a_unicast_pass:
    assert property (@(posedge clk) disable iff (!rst_n)
      rx_da_valid && !rx_da_multicast |=> rx_accept)
    else $error("unicast frame dropped");

endmodule // mac_hash_filter_txq_space

// File: tb/host_model.sv
// Host processor model: drives the register bus of the filter block.
// Assumes callers start accesses only after reset has been released.
module host_model (
  // Clock
  input wire logic clk,
  // Register bus
  output logic [11:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [1:0] reg_be,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------
  // Bus idle state
  // ------------------------------------------------------------
  initial begin
    {reg_wr, reg_rd, reg_be, reg_addr, reg_wdata} = '0;
  end

  // Released lines flip so a stale value can never pass for a live one
  task automatic release_bus();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask

  // One write, strobe held through the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    release_bus();
  endtask

  // One read; the answer stands for the cycle after the taking edge
  task automatic rd(input logic [11:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    d = reg_rdata;
    v = reg_rvalid;
    release_bus();
  endtask

  // Full-word write, then a read of the same word on the very next edge
  task automatic wr_rd(input logic [11:0] a, input logic [15:0] d, output logic [15:0] q,
                       output logic v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_be = 2'b11;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    q = reg_rdata;
    v = reg_rvalid;
    release_bus();
  endtask
endmodule // host_model

// File: tb/mac_hash_filter_txq_space_tb_top.sv
// Self-checking bench for the space request and multicast hash filter.
// Assumes the host model owns the register bus; bench drives the rest.
module mac_hash_filter_txq_space_tb_top
  import hash_txq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] reg_addr;
  logic reg_wr, reg_rd, reg_rvalid, flag, fvalid, accept;
  logic [1:0] reg_be;
  logic [15:0] reg_wdata, reg_rdata, free = '0;
  logic en = 1'b0, clr = 1'b0, hp = 1'b0, ra = 1'b0, mwa = 1'b0, dav = 1'b0, mc = 1'b0;
  logic [47:0] da = '0;
  logic [5:0] hidx_out;
  logic [15:0] mdl [5];
  int fails = 0;
  int checked = 0;

  // ------------------------------------------------------------
  // Clock, design and host
  // ------------------------------------------------------------
  always #20 clk = ~clk;

  mac_hash_filter_txq_space mac_hash_filter_txq_space_inst (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .space_monitor_en(en), .txq_free_dwords(free), .space_flag_clear(clr),
    .tx_space_available_flag(flag), .hash_perfect_mode(hp), .rx_receive_all(ra),
    .rx_multicast_with_addr(mwa), .rx_da_valid(dav), .rx_da(da), .rx_da_multicast(mc),
    .rx_filter_valid(fvalid), .rx_accept(accept), .rx_hash_index(hidx_out));

  host_model host_model_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read with the answer strobe checked as well
  task automatic rdc(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    host_model_inst.rd(a, d, v);
    check({15'h0000, v}, 16'h0001);
    check(d, exp);
  endtask

  // Byte lanes of a partial write: enabled lanes new, the others kept
  function automatic logic [15:0] lane_mix(input logic [15:0] o, input logic [15:0] n,
                                           input logic [1:0] be);
    return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
  endfunction

  // Independent CRC over the address in wire order
  function automatic logic [5:0] hash_of(input logic [47:0] a);
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 48; i++) begin
      c = (c << 1) ^ ((c[31] ^ a[i]) ? CRC_POLY : 32'h00000000);
    end
    return c[31:26];
  endfunction

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the under two hundred cycles of the tests
  initial begin
    #(40 * 20000);
    fails++;
    tally_and_finish();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] r, w, f;
    logic v;
    logic [5:0] h;
    logic [1:0] be;
    void'($urandom(32'h3862A8F4));
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    // Reset values, then an unmapped hole that must read zero
    for (int i = 0; i < 5; i++) begin
      rdc(OFS_TX_NEXT_FRAME_SPACE_REQUEST + 12'(2 * i), 16'h0000);
    end
    rdc(12'h1A8, 16'h0000);
    $display("test reset values done");
    // Full then byte-lane writes to every word
    for (int i = 0; i < 5; i++) begin
      f = 16'($urandom);
      w = 16'($urandom);
      be = 2'($urandom_range(1, 3));
      host_model_inst.wr(OFS_TX_NEXT_FRAME_SPACE_REQUEST + 12'(2 * i), 2'b11, f);
      host_model_inst.wr(OFS_TX_NEXT_FRAME_SPACE_REQUEST + 12'(2 * i), be, w);
      mdl[i] = lane_mix(f, w, be);
      rdc(OFS_TX_NEXT_FRAME_SPACE_REQUEST + 12'(2 * i), mdl[i]);
    end
    $display("test register access done");
    // Request written and read back on consecutive edges, then monitored
    r = 16'($urandom_range(1, 16'hFFFE));
    host_model_inst.wr_rd(OFS_TX_NEXT_FRAME_SPACE_REQUEST, r, w, v);
    check({15'h0000, v}, 16'h0001);
    check(w, r);
    free = r - 16'h0001;
    en = 1'b1;
    repeat (3) @(posedge clk);
    #1 check({15'h0000, flag}, 16'h0000);
    free = r;
    @(posedge clk);
    #1 check({15'h0000, flag}, 16'h0001);
    clr = 1'b1;
    @(posedge clk);
    #1 clr = 1'b0;
    check({15'h0000, flag}, 16'h0000);
    // Still satisfied but already fired: silent until re-armed
    repeat (2) @(posedge clk);
    #1 check({15'h0000, flag}, 16'h0000);
    host_model_inst.wr(OFS_TX_NEXT_FRAME_SPACE_REQUEST, 2'b11, r);
    check({15'h0000, flag}, 16'h0000);
    // Re-armed set lands with a clear in the same cycle: set wins
    clr = 1'b1;
    @(posedge clk);
    #1 clr = 1'b0;
    check({15'h0000, flag}, 16'h0001);
    en = 1'b0;
    $display("test space monitor done");
    // Random addresses, one every cycle; control bits fixed to hash mode multicast for eight, then random
    dav = 1'b1;
    for (int n = 0; n < 60; n++) begin
      {hp, ra, mwa, mc} = (n < 8) ? 4'b1001 : 4'($urandom);
      da = {16'($urandom), 32'($urandom)};
      h = hash_of(da);
      @(posedge clk);
      #1 check({15'h0000, fvalid}, 16'h0001);
      check({10'h000, hidx_out}, {10'h000, h});
      w = (!mc || (ra && mwa) || !hp) ? 16'h0001 : {15'h0000, mdl[1 + h[5:4]][h[3:0]]};
      check({15'h0000, accept}, w);
    end
    dav = 1'b0;
    @(posedge clk);
    #1 check({15'h0000, fvalid}, 16'h0000);
    $display("test hash filter done");
    // Mid-run reset clears the flag and every word again
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    check({15'h0000, flag}, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      rdc(OFS_TX_NEXT_FRAME_SPACE_REQUEST + 12'(2 * i), 16'h0000);
    end
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule // mac_hash_filter_txq_space_tb_top
